/* File: prt_pkg.sv */
// package: register map, fields and constants of the prescaled reload down timer
package prt_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PRT_ADDR_MODE     = 8'h2a;
  localparam logic [7:0] PRT_ADDR_PRE_LO   = 8'h2b;
  localparam logic [7:0] PRT_ADDR_RLD_HI   = 8'h2c;
  localparam logic [7:0] PRT_ADDR_RLD_LO   = 8'h2d;
  localparam logic [7:0] PRT_ADDR_CNT_HI   = 8'h2e;
  localparam logic [7:0] PRT_ADDR_CNT_LO   = 8'h2f;
  localparam logic [7:0] PRT_ADDR_CTRL     = 8'h0c;
  localparam logic [7:0] PRT_ADDR_STATUS   = 8'h0d;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int         PRT_MODE_AUTO_BIT    = 7;
  localparam int         PRT_MODE_RESTART_BIT = 4;
  localparam logic [7:0] PRT_MODE_WMASK       = 8'h9f;
  localparam int         PRT_CTRL_STOP_BIT    = 7;
  localparam int         PRT_CTRL_START_BIT   = 6;
  localparam int         PRT_CTRL_EVEN_BIT    = 0;
  localparam int         PRT_CTRL_MULTI_BIT   = 1;
  localparam int         PRT_STAT_FLAG_BIT    = 0;
  localparam int         PRT_STAT_RUN_BIT     = 1;
  localparam logic [7:0] PRT_REG_RESET        = 8'h00;
  localparam logic [7:0] PRT_READ_ZERO        = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prt_bus_req_t;

  typedef struct packed {
    logic        protocol_auto_timer;
    logic        auto_reload_repeat;
    logic        even_divide_select;
    logic        multi_frame_receive;
    logic [11:0] prescale_value;
    logic [15:0] reload_value;
  } prt_cfg_t;

  typedef enum logic [1:0] {
    PRT_IDLE,
    PRT_RUN
  } prt_state_t;

endpackage : prt_pkg

/* File: prt_prescaler.sv */
// file: prescaler producing one count tick per prescale period of 2p+1 or 2p+2 clocks
`timescale 1ns/1ps
module prt_prescaler
  import prt_pkg::*;
#(
  parameter int PW = 12
)
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // control
  input  wire logic          run,
  input  wire logic          restart,
  input  wire logic [PW-1:0] prescale_value,
  input  wire logic          even_divide_select,
  // tick out
  output logic               tick
);

  logic [PW:0] cnt_q;
  logic [PW:0] cnt_d;
  logic [PW:0] limit;

  // ------------------------------------------------------------
  // divide by 2*p+1 or 2*p+2
  // ------------------------------------------------------------
  always_comb
  begin
    limit = {prescale_value, even_divide_select};
    cnt_d = cnt_q;
    tick  = 1'b0;
    if (!run || restart)
    begin
      cnt_d = '0;
    end
    else if (cnt_q >= limit)
    begin
      cnt_d = '0;
      tick  = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule : prt_prescaler

/* File: prt_regs.sv */
// file: byte-wide register bank with one-cycle read data
`timescale 1ns/1ps
module prt_regs
  import prt_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // bus
  input  wire prt_bus_req_t req,
  output logic [7:0]        rdata,
  // timer state
  input  wire logic [15:0]  count,
  input  wire logic         expiry,
  input  wire logic         running,
  // configuration out
  output prt_cfg_t          cfg,
  output logic              start_pulse,
  output logic              stop_pulse
);

  logic [7:0] mode_q, mode_d, pre_q, pre_d, rh_q, rh_d, rl_q, rl_d, ctl_q, ctl_d;
  logic       flag_q, flag_d;
  logic [7:0] rdata_q, rdata_d;

  function automatic logic hit(input prt_bus_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // ------------------------------------------------------------
  // next register values
  // ------------------------------------------------------------
  always_comb
  begin
    mode_d = mode_q;
    pre_d  = pre_q;
    rh_d   = rh_q;
    rl_d   = rl_q;
    ctl_d  = ctl_q;
    flag_d = flag_q;
    if (hit(req, PRT_ADDR_MODE))   mode_d = req.wdata & PRT_MODE_WMASK;
    if (hit(req, PRT_ADDR_PRE_LO)) pre_d = req.wdata;
    if (hit(req, PRT_ADDR_RLD_HI)) rh_d = req.wdata;
    if (hit(req, PRT_ADDR_RLD_LO)) rl_d = req.wdata;
    if (hit(req, PRT_ADDR_CTRL))
    begin
      ctl_d[PRT_CTRL_EVEN_BIT]  = req.wdata[PRT_CTRL_EVEN_BIT];
      ctl_d[PRT_CTRL_MULTI_BIT] = req.wdata[PRT_CTRL_MULTI_BIT];
    end
    // status bit mirrors the next value of the timer flag
    flag_d = expiry;
    rdata_d = PRT_READ_ZERO;
    if (req.rd)
    begin
      case (req.addr)
        PRT_ADDR_MODE:   rdata_d = mode_q;
        PRT_ADDR_PRE_LO: rdata_d = pre_q;
        PRT_ADDR_RLD_HI: rdata_d = rh_q;
        PRT_ADDR_RLD_LO: rdata_d = rl_q;
        PRT_ADDR_CNT_HI: rdata_d = count[15:8];
        PRT_ADDR_CNT_LO: rdata_d = count[7:0];
        PRT_ADDR_CTRL:   rdata_d = ctl_q;
        PRT_ADDR_STATUS:
        begin
          rdata_d[PRT_STAT_FLAG_BIT] = flag_q;
          rdata_d[PRT_STAT_RUN_BIT]  = running;
        end
        default:         rdata_d = PRT_READ_ZERO;
      endcase
    end
  end

  // configuration views
  assign cfg.protocol_auto_timer = mode_q[PRT_MODE_AUTO_BIT];
  assign cfg.auto_reload_repeat  = mode_q[PRT_MODE_RESTART_BIT];
  assign cfg.even_divide_select  = ctl_q[PRT_CTRL_EVEN_BIT];
  assign cfg.multi_frame_receive = ctl_q[PRT_CTRL_MULTI_BIT];
  assign cfg.prescale_value      = {mode_q[3:0], pre_q};
  assign cfg.reload_value        = {rh_q, rl_q};
  assign start_pulse = hit(req, PRT_ADDR_CTRL) && req.wdata[PRT_CTRL_START_BIT];
  assign stop_pulse  = hit(req, PRT_ADDR_CTRL) && req.wdata[PRT_CTRL_STOP_BIT];
  assign rdata       = rdata_q;

  // registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q  <= PRT_REG_RESET;
      pre_q   <= PRT_REG_RESET;
      rh_q    <= PRT_REG_RESET;
      rl_q    <= PRT_REG_RESET;
      ctl_q   <= PRT_REG_RESET;
      flag_q  <= 1'b0;
      rdata_q <= PRT_READ_ZERO;
    end
    else
    begin
      mode_q  <= mode_d;
      pre_q   <= pre_d;
      rh_q    <= rh_d;
      rl_q    <= rl_d;
      ctl_q   <= ctl_d;
      flag_q  <= flag_d;
      rdata_q <= rdata_d;
    end
  end

endmodule : prt_regs

/* File: prt_timer.sv */
// file: top of the prescaled reload down timer
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - auto mode with multi receive reloads at zero
// - stop-now control bit halts the timer
// - auto bit clear: registers only control
// - auto restart reloads and keeps counting
// - no restart and no auto multi receive: stop at zero, set flag
// - prescaler is mode nibble plus low byte
// - odd mode divides by 2p+1
// - even mode divides by 2p+2
// - even mode selection resets cleared
// - start event loads 16-bit reload value
// - reload writes wait for next start or reload at zero
// - live count readable as two bytes
module prt_timer
  import prt_pkg::*;
#(
  parameter int CW = 16
)
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // register port
  input  wire logic [7:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic [7:0]        rdata,
  // protocol start event
  input  wire logic         protocol_start,
  // status
  output logic              timer_expiry_flag,
  output logic              timer_running
);

  prt_bus_req_t req;
  prt_cfg_t     cfg;
  prt_state_t   st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          flag_q, flag_d;
  logic          run_q, run_d;
  logic          start_pulse, stop_pulse, tick, start, expiry;

  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  prt_regs u_regs (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .req         (req),
    .rdata       (rdata),
    .count       (cnt_q),
    .expiry      (flag_d), // status bit follows the flag
    .running     (st_q == PRT_RUN),
    .cfg         (cfg),
    .start_pulse (start_pulse),
    .stop_pulse  (stop_pulse)
  );

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  prt_prescaler #(.PW(12)) u_pre (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .run                (st_q == PRT_RUN),
    .restart            (start),
    .prescale_value     (cfg.prescale_value),
    .even_divide_select (cfg.even_divide_select),
    .tick               (tick)
  );

  // protocol start only counts in auto mode
  assign start = start_pulse || (protocol_start && cfg.protocol_auto_timer);

  // ------------------------------------------------------------
  // counter state machine
  // ------------------------------------------------------------
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    expiry = 1'b0;
    case (st_q)
      PRT_IDLE:
      begin
        if (start && !stop_pulse)
        begin
          cnt_d = cfg.reload_value;
          st_d  = PRT_RUN;
        end
      end
      PRT_RUN:
      begin
        if (stop_pulse)
          st_d = PRT_IDLE;
        else if (start)
          cnt_d = cfg.reload_value;
        else if (tick)
        begin
          if (cnt_q == '0)
          begin
            expiry = 1'b1;
            if (cfg.auto_reload_repeat)
              cnt_d = cfg.reload_value;
            else if (cfg.protocol_auto_timer && cfg.multi_frame_receive)
              cnt_d = cfg.reload_value;
            else
              st_d = PRT_IDLE;
          end
          else
            cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = PRT_IDLE;
    endcase
    flag_d = flag_q | expiry;
    if (start) flag_d = 1'b0;
    // write one clears; a same-cycle expiry wins
    if (wr && addr == PRT_ADDR_STATUS && wdata[PRT_STAT_FLAG_BIT]) flag_d = 1'b0;
    if (expiry) flag_d = 1'b1;
    run_d = (st_d == PRT_RUN);
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q   <= PRT_IDLE;
      cnt_q  <= '0;
      flag_q <= 1'b0;
      run_q  <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
      run_q  <= run_d;
    end
  end

  assign timer_expiry_flag = flag_q;
  assign timer_running     = run_q;

endmodule : prt_timer

/* File: prt_timer_asserts.sv */
// checker: concurrent assertions on the timer top ports
`timescale 1ns/1ps
module prt_timer_asserts
  import prt_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // event and status
  input wire logic       protocol_start,
  input wire logic       timer_expiry_flag,
  input wire logic       timer_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic auto_q;
  logic auto_d;
  logic ctl_w;
  // --------------------------------------------------
  // helper: mirror of the protocol-linked mode bit
  // --------------------------------------------------
  assign ctl_w = wr && (addr == PRT_ADDR_CTRL);
  always_comb
  begin
    auto_d = auto_q;
    if (wr && addr == PRT_ADDR_MODE)
      auto_d = wdata[PRT_MODE_AUTO_BIT];
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      auto_q <= 1'b0;
    else
      auto_q <= auto_d;
  end
  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside read");
  a_stop_halts: assert property (ctl_w && wdata[7] |=> !timer_running)
    else $error("timer still running after stop");
  a_start_runs: assert property (ctl_w && wdata[7:6] == 2'b01 |=> timer_running)
    else $error("timer not running after start");
  a_mode_gap_zero: assert property (rd && addr == PRT_ADDR_MODE |=> rdata[6:5] == 2'b00)
    else $error("mode reserved bits not zero");
  a_unmapped_zero: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_view: assert property (rd && addr == PRT_ADDR_STATUS |=>
    rdata[1:0] == {$past(timer_running), $past(timer_expiry_flag)})
    else $error("status read differs from flags");
  a_run_cause: assert property ($rose(timer_running) |->
    $past(ctl_w) || ($past(protocol_start) && $past(auto_q)))
    else $error("timer started without start event");
  a_proto_ignored: assert property (protocol_start && !auto_q && !timer_running && !wr
    |=> !timer_running)
    else $error("protocol event started timer in manual mode");
  a_idle_hold: assert property (!timer_running && !wr && !protocol_start
    |=> !timer_running && $stable(timer_expiry_flag))
    else $error("stopped timer changed state");
  // main scenarios reached
  c_start: cover property (ctl_w && wdata[6]);
  c_expiry: cover property ($rose(timer_expiry_flag));
  c_proto: cover property (protocol_start && auto_q);
endmodule : prt_timer_asserts

bind prt_timer prt_timer_asserts u_prt_timer_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .protocol_start(protocol_start), .timer_expiry_flag(timer_expiry_flag),
  .timer_running(timer_running));

/* File: test_prescaled_reload_down_timer.sv */
// testbench: directed scenarios for the timer top
`timescale 1ns/1ps
module test_prescaled_reload_down_timer
  import prt_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       protocol_start = 1'b0;
  logic [7:0] rdata;
  logic       flag;
  logic       running;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         ta;
  int         tb;
  prt_timer u_prt_timer (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .protocol_start(protocol_start),
    .timer_expiry_flag(flag), .timer_running(running));
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  // --------------------------------------------------
  // bus, compare and closing tasks
  // --------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk("register", {8'h00, e}, {8'h00, d});
  endtask : chk_rd
  task automatic tally_and_finish;
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // cycles from start to expiry for a reload value
  task automatic time_run(input logic [7:0] rl, input logic ev, output int n);
    wr_reg(PRT_ADDR_RLD_HI, 8'h00);
    wr_reg(PRT_ADDR_RLD_LO, rl);
    wr_reg(PRT_ADDR_STATUS, 8'h01);
    wr_reg(PRT_ADDR_CTRL, {7'h20, ev});
    n = 0;
    while (flag !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 2000)
      begin
        miscompares++;
        tally_and_finish();
      end
    end
  endtask : time_run
  // --------------------------------------------------
  // scenarios
  // --------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 4; i++)
      chk_rd(PRT_ADDR_MODE + 8'(i), PRT_REG_RESET);
    chk_rd(8'h00, PRT_READ_ZERO);
    wr_reg(PRT_ADDR_MODE, 8'hff);
    chk_rd(PRT_ADDR_MODE, PRT_MODE_WMASK);
  endtask : t_regs
  task automatic t_divide;
    wr_reg(PRT_ADDR_MODE, 8'h00);
    wr_reg(PRT_ADDR_PRE_LO, 8'h02);
    time_run(8'h03, 1'b0, ta);
    chk("running", 16'h0, {15'h0, running});
    chk_rd(PRT_ADDR_CNT_LO, 8'h00);
    chk_rd(PRT_ADDR_STATUS, 8'h01);
    wr_reg(PRT_ADDR_STATUS, 8'h01);
    chk("flag", 16'h0, {15'h0, flag});
    time_run(8'h01, 1'b0, tb);
    chk("odd span", 16'd10, 16'(ta - tb));
    time_run(8'h03, 1'b1, ta);
    time_run(8'h01, 1'b1, tb);
    chk("even span", 16'd12, 16'(ta - tb));
  endtask : t_divide
  task automatic t_reload;
    wr_reg(PRT_ADDR_MODE, 8'h01);
    wr_reg(PRT_ADDR_PRE_LO, 8'hff);
    wr_reg(PRT_ADDR_RLD_HI, 8'h12);
    wr_reg(PRT_ADDR_RLD_LO, 8'h34);
    wr_reg(PRT_ADDR_CTRL, 8'h40);
    chk_rd(PRT_ADDR_CNT_HI, 8'h12);
    chk_rd(PRT_ADDR_CNT_LO, 8'h34);
    wr_reg(PRT_ADDR_RLD_HI, 8'h00);
    wr_reg(PRT_ADDR_RLD_LO, 8'h05);
    chk_rd(PRT_ADDR_CNT_HI, 8'h12);
    wr_reg(PRT_ADDR_CTRL, 8'h80);
    repeat (1100) @(posedge clk_sys);
    chk_rd(PRT_ADDR_CNT_LO, 8'h34);
    wr_reg(PRT_ADDR_CTRL, 8'h40);
    chk_rd(PRT_ADDR_CNT_LO, 8'h05);
    wr_reg(PRT_ADDR_CTRL, 8'h80);
  endtask : t_reload
  task automatic t_restart;
    wr_reg(PRT_ADDR_MODE, 8'h10);
    wr_reg(PRT_ADDR_PRE_LO, 8'h00);
    wr_reg(PRT_ADDR_RLD_LO, 8'h02);
    wr_reg(PRT_ADDR_CTRL, 8'h40);
    repeat (50) @(posedge clk_sys);
    #1;
    chk("running", 16'h1, {15'h0, running});
    chk("flag", 16'h1, {15'h0, flag});
    wr_reg(PRT_ADDR_CTRL, 8'h80);
    chk("running", 16'h0, {15'h0, running});
  endtask : t_restart
  task automatic pulse_proto;
    @(posedge clk_sys);
    protocol_start <= 1'b1;
    @(posedge clk_sys);
    protocol_start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : pulse_proto
  task automatic t_proto;
    wr_reg(PRT_ADDR_MODE, 8'h00);
    pulse_proto();
    chk("running", 16'h0, {15'h0, running});
    wr_reg(PRT_ADDR_MODE, 8'h80);
    wr_reg(PRT_ADDR_CTRL, 8'h02);
    pulse_proto();
    repeat (60) @(posedge clk_sys);
    #1;
    chk("running", 16'h1, {15'h0, running});
    wr_reg(PRT_ADDR_CTRL, 8'h82);
    chk("running", 16'h0, {15'h0, running});
  endtask : t_proto
  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_divide();
    t_reload();
    t_restart();
    t_proto();
    tally_and_finish();
  end
endmodule : test_prescaled_reload_down_timer
